// >>> test/pmu_host_model.sv
`timescale 1ns/1ps
// host side: drives latch enable and chip select pins
module pmu_host_model
(
  input  wire logic core_clk_i,
  input  wire logic pulse_i,
  input  wire logic idle_level_i,
  input  wire logic deselect_i,
  output logic      address_latch_o,
  output logic      chip_select_n_o
);
  logic div_r = 1'b0;

  // pulsing keeps well under 15 counter clocks between latch pulses
  always @(posedge core_clk_i)
  begin
    div_r <= ~div_r;
    if (!pulse_i)
      address_latch_o <= idle_level_i;
    else if (div_r)
      address_latch_o <= ~address_latch_o;
    chip_select_n_o <= deselect_i;
  end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module testbench
  import pmu_pkg::*;
;
  logic        core_clk_i;
  logic        reset_i;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic        pe7, ext_clk, act, pulse, idle_lvl, desel, ale, cs_n;
  pmu_ctl_t    ctl;
  int          n_fail, check_count, cyc;

  pmu_unit dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_select_n_i(cs_n), .address_latch_i(ale),
    .port_e_pin7_input_i(pe7), .external_clock_input_i(ext_clk),
    .array_inputs_active_i(act), .ctl_o(ctl));
  pmu_host_model host (.core_clk_i(core_clk_i), .pulse_i(pulse),
    .idle_level_i(idle_lvl), .deselect_i(desel),
    .address_latch_o(ale), .chip_select_n_o(cs_n));

  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  task test_done();
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, run needs about a thousand cycles
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one apb transfer, held until pready is sampled
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // counter clock pulses on the pin picked by src
  task tick(input logic src, input int n);
    repeat (n)
    begin
      if (src)
        ext_clk <= 1'b1;
      else
        pe7 <= 1'b1;
      wt(2);
      if (src)
        ext_clk <= 1'b0;
      else
        pe7 <= 1'b0;
      wt(2);
    end
  endtask

  task t_regs();
    xfer(1'b0, PMU_MODE_A_ADDR, 32'h0);
    `CHK("mode_a", {24'h0, PMU_MODE_A_RST}, rdat)
    xfer(1'b0, PMU_MODE_B_ADDR, 32'h0);
    `CHK("mode_b", {24'h0, PMU_MODE_B_RST}, rdat)
    xfer(1'b1, PMU_MODE_B_ADDR, 32'hff);
    xfer(1'b0, PMU_MODE_B_ADDR, 32'h0);
    `CHK("mode_b mask", {24'h0, PMU_B_WMASK}, rdat)
    xfer(1'b1, PMU_MODE_A_ADDR, 32'h5a);
    xfer(1'b0, PMU_MODE_A_ADDR, 32'h0);
    `CHK("mode_a rw", 32'h5a, rdat)
    xfer(1'b0, 8'hc0, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdat)
    xfer(1'b1, PMU_MODE_A_ADDR, 32'h0);
    xfer(1'b1, PMU_MODE_B_ADDR, 32'h0);
  endtask

  task t_cs();
    desel <= 1'b1;
    wt(6);
    `CHK("cs standby", 1'b1, ctl.standby)
    `CHK("cs bus buf", 1'b0, ctl.bus_buf_en)
    `CHK("cs host path", 1'b0, ctl.host_to_array_en)
    `CHK("cs core", 1'b0, ctl.core_on)
    `CHK("cs array", 1'b1, ctl.array_on)
    desel <= 1'b0;
    wt(6);
    `CHK("sel standby", 1'b0, ctl.standby)
    `CHK("sel bus buf", 1'b1, ctl.bus_buf_en)
  endtask

  // 14 ticks must not trip, the 15th trips when counting is legal
  task t_apd(input logic [7:0] ma, input logic [7:0] mb, input logic src,
             input logic lvl, input logic ex);
    logic [31:0] st_exp;
    pulse <= 1'b1;
    xfer(1'b1, PMU_MODE_A_ADDR, {24'h0, ma});
    xfer(1'b1, PMU_MODE_B_ADDR, {24'h0, mb});
    idle_lvl <= lvl;
    pulse <= 1'b0;
    wt(6);
    tick(src, 14);
    wt(6);
    `CHK("pd early", 1'b0, ctl.power_down_signal)
    tick(src, 1);
    wt(6);
    `CHK("pd", ex, ctl.power_down_signal)
    `CHK("sleep", ex & mb[1] & ma[1], ctl.sleep)
    `CHK("core", ~ex, ctl.core_on)
    `CHK("array", 1'b1, ctl.array_on)
    `CHK("external_clock_input buf", ~(ex & (&ma[7:5])), ctl.external_clock_input_buf_en)
    // status: overflow, count, sleep, down, synced chip select
    st_exp = {24'h0, ex, {4{ex}}, ex & mb[1] & ma[1],
              ex & ~(mb[1] & ma[1]), 1'b0};
    xfer(1'b0, PMU_STATUS_ADDR, 32'h0);
    `CHK("status", st_exp, rdat)
    `CHK("status err", 1'b0, rerr)
    pulse <= 1'b1;
    wt(8);
    `CHK("wake pd", 1'b0, ctl.power_down_signal)
    `CHK("wake sleep", 1'b0, ctl.sleep)
  endtask

  task t_gate(input logic [7:0] ma);
    xfer(1'b1, PMU_MODE_A_ADDR, {24'h0, ma});
    wt(2);
    `CHK("mem saver", ma[3], ctl.mem_saver)
    `CHK("array clk", ~ma[5], ctl.array_clk_en)
    `CHK("macro clk", ~ma[6], ctl.macro_clk_en)
    `CHK("timer clk", ~ma[7], ctl.timer_clk_en)
  endtask

  task t_static(input logic [7:0] ma, input logic ex);
    xfer(1'b1, PMU_MODE_A_ADDR, {24'h0, ma});
    repeat (8)
    begin
      ext_clk <= ~ext_clk;
      wt(1);
    end
    `CHK("array clk wake", ex, ctl.array_on)
  endtask

  initial
  begin
    reset_i     = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    pe7         = 1'b0;
    ext_clk     = 1'b0;
    act         = 1'b1;
    pulse       = 1'b0;
    idle_lvl    = 1'b0;
    desel       = 1'b0;
    n_fail      = 0;
    check_count = 0;
    wt(20);
    reset_i <= 1'b0;
    pulse   <= 1'b1;
    wt(4);
    t_regs();
    t_cs();
    // software keeps the timer clock gate set while running the countdown
    t_apd(8'h85, 8'h00, 1'b0, 1'b0, 1'b1);
    t_apd(8'h81, 8'h00, 1'b0, 1'b0, 1'b0);
    t_apd(8'h87, 8'h00, 1'b0, 1'b0, 1'b0);
    t_apd(8'h87, 8'h00, 1'b0, 1'b1, 1'b1);
    t_apd(8'h85, 8'h01, 1'b0, 1'b0, 1'b0);
    t_apd(8'h85, 8'h01, 1'b1, 1'b0, 1'b1);
    t_apd(8'h87, 8'h02, 1'b0, 1'b1, 1'b1);
    t_apd(8'h85, 8'h02, 1'b0, 1'b0, 1'b1);
    t_apd(8'he5, 8'h00, 1'b0, 1'b0, 1'b1);
    t_gate(8'hc8);
    t_gate(8'h20);
    act <= 1'b0;
    xfer(1'b1, PMU_MODE_A_ADDR, 32'h30);
    wt(6);
    `CHK("static array", 1'b0, ctl.array_on)
    `CHK("static standby", 1'b1, ctl.standby)
    act <= 1'b1;
    wt(6);
    `CHK("active array", 1'b1, ctl.array_on)
    act <= 1'b0;
    t_static(8'h10, 1'b1);
    t_static(8'h30, 1'b0);
    test_done();
  end
endmodule

// >>> verilog/pmu_pkg.sv
package pmu_pkg;
  // apb register map, byte addresses
  localparam logic [7:0] PMU_MODE_A_ADDR   = 8'hb0;
  localparam logic [7:0] PMU_MODE_B_ADDR   = 8'hb4;
  localparam logic [7:0] PMU_STATUS_ADDR   = 8'hb8;
  // mode register a fields
  localparam int PMU_A_APD_ARM      = 0;
  localparam int PMU_A_IDLE_LEVEL   = 1;
  localparam int PMU_A_CNT_EN       = 2;
  localparam int PMU_A_MEM_SAVER    = 3;
  localparam int PMU_A_TURBO_OFF    = 4;
  localparam int PMU_A_ARRAY_CLK    = 5;
  localparam int PMU_A_MACRO_CLK    = 6;
  localparam int PMU_A_TIMER_CLK    = 7;
  // mode register b fields
  localparam int PMU_B_CLK_SEL      = 0;
  localparam int PMU_B_SLEEP_EN     = 1;
  localparam logic [7:0] PMU_B_WMASK = 8'h03;
  // reset values
  localparam logic [7:0] PMU_MODE_A_RST = 8'h00;
  localparam logic [7:0] PMU_MODE_B_RST = 8'h00;
  // countdown terminal count
  localparam logic [3:0] PMU_CNT_TOP    = 4'hf;
  // idle cycles before array inputs count as static
  localparam logic [1:0] PMU_STATIC_CYC = 2'h2;

  typedef struct packed {
    logic standby;
    logic sleep;
    logic power_down_signal;
    logic bus_buf_en;
    logic host_to_array_en;
    logic core_on;
    logic array_on;
    logic mem_saver;
    logic array_clk_en;
    logic macro_clk_en;
    logic timer_clk_en;
    logic external_clock_input_buf_en;
  } pmu_ctl_t;
endpackage

// >>> verilog/pmu_unit.sv
`timescale 1ns/1ps
module pmu_unit
  import pmu_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chip_select_n_i,
  input  wire logic        address_latch_i,
  input  wire logic        port_e_pin7_input_i,
  input  wire logic        external_clock_input_i,
  input  wire logic        array_inputs_active_i,
  output pmu_ctl_t         ctl_o
);

  typedef enum logic [1:0] {PMU_RUN, PMU_DOWN, PMU_SLEEP} pmu_state_t;

  logic [7:0]  mode_a_r;
  logic [7:0]  mode_b_r;
  logic [2:0]  cs_sync_r;
  logic [2:0]  ale_sync_r;
  logic [2:0]  pin_sync_r;
  logic [2:0]  clk_sync_r;
  logic [1:0]  act_sync_r;
  logic [3:0]  cnt_r;
  logic        ovf_r;
  logic [1:0]  static_r;
  pmu_state_t  state_r;
  pmu_state_t  state_nxt;
  pmu_ctl_t    ctl_nxt;
  logic        ale_pulse;
  logic        ale_idle;
  logic        cnt_tick;
  logic        counting;
  logic        cs_n;
  logic        inputs_static;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;

  // rising edge detect on a synchronised sample
  function automatic logic rise_of(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  // any change on a synchronised sample
  function automatic logic edge_of(input logic [2:0] s);
    return s[1] ^ s[2];
  endfunction

  // pins pass two flops; bit 2 is the edge history
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cs_sync_r  <= 3'h7;
      ale_sync_r <= 3'h0;
      pin_sync_r <= 3'h0;
      clk_sync_r <= 3'h0;
      act_sync_r <= 2'h0;
    end
    else
    begin
      cs_sync_r  <= {cs_sync_r[1:0], chip_select_n_i};
      ale_sync_r <= {ale_sync_r[1:0], address_latch_i};
      pin_sync_r <= {pin_sync_r[1:0], port_e_pin7_input_i};
      clk_sync_r <= {clk_sync_r[1:0], external_clock_input_i};
      act_sync_r <= {act_sync_r[0], array_inputs_active_i};
    end
  end

  assign cs_n      = cs_sync_r[1];
  assign ale_pulse = edge_of(ale_sync_r);
  // level must also be stable this cycle, so a pulse never counts
  assign ale_idle  = !ale_pulse &&
                     (ale_sync_r[1] == mode_a_r[PMU_A_IDLE_LEVEL]);
  // counter clock source; gated off once standby was reached
  assign cnt_tick  = (state_r == PMU_RUN) &&
                     (mode_b_r[PMU_B_CLK_SEL] ? rise_of(clk_sync_r)
                                              : rise_of(pin_sync_r));
  assign counting  = mode_a_r[PMU_A_CNT_EN] && ale_idle;

  // apb slave, zero wait states
  assign addr_ok = (paddr == PMU_MODE_A_ADDR) ||
                   (paddr == PMU_MODE_B_ADDR) ||
                   (paddr == PMU_STATUS_ADDR);
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;

  // mode registers, rewritable at any time
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      mode_a_r <= PMU_MODE_A_RST;
      mode_b_r <= PMU_MODE_B_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == PMU_MODE_A_ADDR)
        mode_a_r <= pwdata[7:0];
      if (paddr == PMU_MODE_B_ADDR)
        mode_b_r <= pwdata[7:0] & PMU_B_WMASK;
    end
  end

  // read data registered in setup so access phase completes at once
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd)
      begin
        case (paddr)
          PMU_MODE_A_ADDR: prdata <= {24'h00_0000, mode_a_r};
          PMU_MODE_B_ADDR: prdata <= {24'h00_0000, mode_b_r};
          PMU_STATUS_ADDR: prdata <= {24'h00_0000, ovf_r, cnt_r,
                                      (state_r == PMU_SLEEP),
                                      (state_r == PMU_DOWN), cs_n};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // 4-bit countdown; sticks at top until latch enable moves again
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      cnt_r <= 4'h0;
      ovf_r <= 1'b0;
    end
    else if (!counting)
    begin
      cnt_r <= 4'h0;
      ovf_r <= 1'b0;
    end
    else if (cnt_tick && !ovf_r)
    begin
      cnt_r <= cnt_r + 4'h1;
      ovf_r <= (cnt_r == PMU_CNT_TOP - 4'h1);
    end
  end

  // array input activity filter for the no-turbo static case
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      static_r <= 2'h0;
    else if (act_sync_r[1] ||
             (!mode_a_r[PMU_A_ARRAY_CLK] && edge_of(clk_sync_r)))
      static_r <= 2'h0;
    else if (static_r != PMU_STATIC_CYC)
      static_r <= static_r + 2'h1;
  end

  assign inputs_static = mode_a_r[PMU_A_TURBO_OFF] &&
                         (static_r == PMU_STATIC_CYC);

  // standby state
  always_comb
  begin
    state_nxt = PMU_RUN;
    if (ovf_r && !ale_pulse)
    begin
      if (mode_b_r[PMU_B_SLEEP_EN] && mode_a_r[PMU_A_CNT_EN] &&
          mode_a_r[PMU_A_IDLE_LEVEL])
        state_nxt = PMU_SLEEP;
      else
        state_nxt = PMU_DOWN;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_r <= PMU_RUN;
    else
    begin
      case (state_nxt)
        PMU_SLEEP: state_r <= PMU_SLEEP;
        PMU_DOWN:  state_r <= PMU_DOWN;
        default:   state_r <= PMU_RUN;
      endcase
    end
  end

  // control outputs
  always_comb
  begin
    ctl_nxt = '0;
    ctl_nxt.power_down_signal = (state_nxt != PMU_RUN);
    ctl_nxt.sleep    = (state_nxt == PMU_SLEEP);
    ctl_nxt.standby  = cs_n || inputs_static ||
                       ctl_nxt.power_down_signal;
    ctl_nxt.bus_buf_en       = !cs_n;
    ctl_nxt.host_to_array_en = !cs_n;
    ctl_nxt.core_on  = !ctl_nxt.standby;
    // array is never shut by standby, only by no-turbo idleness
    ctl_nxt.array_on = !inputs_static;
    ctl_nxt.mem_saver    = mode_a_r[PMU_A_MEM_SAVER];
    ctl_nxt.array_clk_en = !mode_a_r[PMU_A_ARRAY_CLK];
    ctl_nxt.macro_clk_en = !mode_a_r[PMU_A_MACRO_CLK];
    ctl_nxt.timer_clk_en = !mode_a_r[PMU_A_TIMER_CLK];
    ctl_nxt.external_clock_input_buf_en =
      !(&mode_a_r[PMU_A_TIMER_CLK:PMU_A_ARRAY_CLK] && ovf_r);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctl_o <= '{default: 1'b0, core_on: 1'b1, array_on: 1'b1,
                 array_clk_en: 1'b1, macro_clk_en: 1'b1,
                 timer_clk_en: 1'b1, external_clock_input_buf_en: 1'b1};
    else
      ctl_o <= ctl_nxt;
  end

  // checks
  sequence s_idle_run;
    counting && cnt_tick && !ovf_r;
  endsequence

  property p_cs_down;
    @(posedge core_clk_i) disable iff (reset_i)
    cs_n |=> ctl_o.standby && !ctl_o.bus_buf_en;
  endproperty
  a_cs_down: assert property (p_cs_down)
    else $error("chip select high without standby");

  property p_block_host;
    @(posedge core_clk_i) disable iff (reset_i)
    cs_n |=> !ctl_o.host_to_array_en;
  endproperty
  a_block_host: assert property (p_block_host)
    else $error("host inputs reach array while deselected");

  property p_array_alive;
    @(posedge core_clk_i) disable iff (reset_i)
    !mode_a_r[PMU_A_TURBO_OFF] |=> ctl_o.array_on;
  endproperty
  a_array_alive: assert property (p_array_alive)
    else $error("array off with turbo on");

  property p_ovf_after_15;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(ovf_r) |-> cnt_r == PMU_CNT_TOP;
  endproperty
  a_ovf_after_15: assert property (p_ovf_after_15)
    else $error("overflow not at fifteen clocks");

  property p_clear_idle;
    @(posedge core_clk_i) disable iff (reset_i)
    !counting |=> cnt_r == 4'h0 && !ovf_r;
  endproperty
  a_clear_idle: assert property (p_clear_idle)
    else $error("counter not cleared while idle");

  property p_count_step;
    @(posedge core_clk_i) disable iff (reset_i)
    s_idle_run |=> cnt_r == $past(cnt_r) + 4'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter missed a tick");

  property p_wake;
    @(posedge core_clk_i) disable iff (reset_i)
    ale_pulse |=> state_r == PMU_RUN ##1 !ctl_o.power_down_signal;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on latch pulse");

  property p_sleep_cond;
    @(posedge core_clk_i) disable iff (reset_i)
    state_r == PMU_SLEEP |-> $past(mode_b_r[PMU_B_SLEEP_EN]);
  endproperty
  a_sleep_cond: assert property (p_sleep_cond)
    else $error("sleep without enable");

  property p_tick_gate;
    @(posedge core_clk_i) disable iff (reset_i)
    state_r != PMU_RUN |=> cnt_r == $past(cnt_r) || cnt_r == 4'h0;
  endproperty
  a_tick_gate: assert property (p_tick_gate)
    else $error("counter ran during standby");

  property p_ovf_down;
    @(posedge core_clk_i) disable iff (reset_i)
    ovf_r && !ale_pulse |=> ctl_o.power_down_signal;
  endproperty
  a_ovf_down: assert property (p_ovf_down)
    else $error("overflow without power-down");

  property p_external_clock_input_off;
    @(posedge core_clk_i) disable iff (reset_i)
    &mode_a_r[PMU_A_TIMER_CLK:PMU_A_ARRAY_CLK] && ovf_r
      |=> !ctl_o.external_clock_input_buf_en;
  endproperty
  a_external_clock_input_off: assert property (p_external_clock_input_off)
    else $error("clock input buffer left on");

  property p_apd_off;
    @(posedge core_clk_i) disable iff (reset_i)
    !mode_a_r[PMU_A_CNT_EN] |=> cnt_r == 4'h0 && !ovf_r;
  endproperty
  a_apd_off: assert property (p_apd_off)
    else $error("counter ran while disabled");

endmodule
